// *** rtl/rms_pkg.sv ***
// Package of constants and types for the receive mode command store block.
package rms_pkg;
   // ------------------------------------------------------------------
   // Information word field positions
   // ------------------------------------------------------------------
   localparam int INVALID_WORD_BIT = 14;
   localparam int GAP_FAULT_BIT = 13;
   localparam int WORD_COUNT_BIT = 12;
   localparam int SYNC_TYPE_BIT = 11;
   localparam int MSG_FAULT_BIT = 10;
   localparam int BUSY_BIT = 9;
   localparam int ILLEGAL_BIT = 8;
   localparam int BUS_SELECT_BIT = 5;
   localparam int MODE_CODE_LSB = 0;
   localparam int MODE_CODE_W = 5;
   // ------------------------------------------------------------------
   // Record layout, mode code ranges and reset values
   // ------------------------------------------------------------------
   localparam logic [15:0] INFO_OFFSET = 16'h0000;
   localparam logic [15:0] TAG_OFFSET = 16'h0001;
   localparam logic [15:0] DATA_OFFSET = 16'h0002;
   localparam logic [4:0] MC_DATA_FIRST = 5'h10;
   localparam logic [4:0] MC_UNDEF_A = 5'h10;
   localparam logic [4:0] MC_UNDEF_B = 5'h12;
   localparam logic [4:0] MC_UNDEF_C = 5'h13;
   localparam logic [15:0] WORD_RESET = 16'h0000;
   localparam logic [1:0] CNT_RESET = 2'h0;
   // ------------------------------------------------------------------
   // Write sequencer states, Gray coded along the usual path
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      RMS_IDLE = 2'b00,
      RMS_INFO = 2'b01,
      RMS_TAG = 2'b11,
      RMS_DATA = 2'b10
   } rms_state_t;
endpackage

// *** rtl/rms_info_build.sv ***
// Combinational builder of the receive mode message information word.
`timescale 1ns/1ps
module rms_info_build (
   // Error and status inputs
   input wire logic invalid_word_i,
   input wire logic gap_fault_i,
   input wire logic word_count_i,
   input wire logic sync_type_i,
   input wire logic busy_i,
   input wire logic illegal_i,
   input wire logic bus_select_i,
   input wire logic [4:0] mode_code_i,
   // Built word
   output logic [15:0] info_word_o
);
   always_comb begin
      info_word_o = rms_pkg::WORD_RESET;
      info_word_o[rms_pkg::INVALID_WORD_BIT] = invalid_word_i;
      info_word_o[rms_pkg::GAP_FAULT_BIT] = gap_fault_i;
      info_word_o[rms_pkg::WORD_COUNT_BIT] = word_count_i;
      info_word_o[rms_pkg::SYNC_TYPE_BIT] = sync_type_i;
      info_word_o[rms_pkg::MSG_FAULT_BIT] = invalid_word_i | gap_fault_i
         | word_count_i | sync_type_i;
      info_word_o[rms_pkg::BUSY_BIT] = busy_i;
      info_word_o[rms_pkg::ILLEGAL_BIT] = illegal_i;
      info_word_o[rms_pkg::BUS_SELECT_BIT] = bus_select_i;
      info_word_o[rms_pkg::MODE_CODE_LSB +: rms_pkg::MODE_CODE_W] = mode_code_i;
   end
endmodule

// *** rtl/rms_word_reg.sv ***
// Registered holding stage for one captured mode data word.
`timescale 1ns/1ps
module rms_word_reg (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   // Load port
   input wire logic load_i,
   input wire logic [15:0] word_i,
   // Held word
   output logic [15:0] word_o
);
   typedef struct packed {
      logic [15:0] word;
   } rms_hold_t;
   rms_hold_t st;
   rms_hold_t next_st;
   always_comb begin
      next_st = st;
      if (load_i) begin
         next_st.word = word_i;
      end
   end
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         st <= '{word: rms_pkg::WORD_RESET};
      end else begin
         st <= next_st;
      end
   end
   assign word_o = st.word;
endmodule

// *** rtl/rms_cmd_store.sv ***
// Receive mode command record writer into shared RAM.
`timescale 1ns/1ps
module rms_cmd_store #(
   parameter int ADDR_W = 16
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   // Message from the protocol engine
   input wire logic msg_done_i,
   input wire logic [4:0] mode_code_i,
   input wire logic [ADDR_W-1:0] data_ptr_i,
   input wire logic data_valid_i,
   input wire logic [15:0] data_word_i,
   input wire logic [15:0] time_tag_i,
   input wire logic bus_select_i,
   // Error flags seen during the message
   input wire logic invalid_word_i,
   input wire logic gap_fault_i,
   input wire logic word_count_i,
   input wire logic sync_type_i,
   // Configuration and busy sources
   input wire logic illegal_bit_i,
   input wire logic undefined_mode_invalid_i,
   input wire logic global_busy_i,
   input wire logic per_command_busy_i,
   // Response decision
   output logic respond_in_form_o,
   output logic responded_busy_o,
   // Mode data action
   output logic mode_data_valid_o,
   output logic [4:0] mode_data_code_o,
   output logic [15:0] mode_data_o,
   // Shared RAM write port
   output logic ram_we_o,
   output logic [ADDR_W-1:0] ram_addr_o,
   output logic [15:0] ram_wdata_o,
   input wire logic ram_ready_i,
   // Sequencer status
   output logic busy_o
);
   if (ADDR_W < 2 || ADDR_W > 16) begin : g_addr_w_check
      $error("ADDR_W must lie between 2 and 16");
   end

   // ------------------------------------------------------------------
   // Helper functions
   // ------------------------------------------------------------------
   function automatic logic has_data(input logic [4:0] mc);
      has_data = (mc >= rms_pkg::MC_DATA_FIRST);
   endfunction

   function automatic logic is_undefined(input logic [4:0] mc);
      is_undefined = !has_data(mc) || mc == rms_pkg::MC_UNDEF_A
         || mc == rms_pkg::MC_UNDEF_B || mc == rms_pkg::MC_UNDEF_C;
   endfunction

   function automatic logic [ADDR_W-1:0] offs(input logic [ADDR_W-1:0] base,
                                             input logic [15:0] off);
      offs = base + off[ADDR_W-1:0];
   endfunction

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef struct packed {
      rms_pkg::rms_state_t state;
      logic [ADDR_W-1:0] base;
      logic [15:0] info;
      logic [15:0] tag;
      logic with_data;
      logic data_out_valid;
      logic [4:0] data_code;
      logic [15:0] data_out;
   } rms_store_t;

   rms_store_t st;
   rms_store_t next_st;
   logic busy_now;
   logic illegal_now;
   logic [15:0] info_now;
   logic [15:0] held_data;
   logic data_good;

   // An illegal or disabled undefined code is never a normal answer.
   assign illegal_now = illegal_bit_i
      || (is_undefined(mode_code_i) && undefined_mode_invalid_i);
   // Busy is only reported on commands that would otherwise answer normally.
   assign busy_now = !illegal_now && (global_busy_i || per_command_busy_i);
   assign respond_in_form_o = msg_done_i && !illegal_now && !busy_now;
   assign responded_busy_o = msg_done_i && busy_now;
   assign data_good = data_valid_i && !invalid_word_i && !sync_type_i && !gap_fault_i;

   rms_info_build rms_info_build_i (
      .invalid_word_i(invalid_word_i),
      .gap_fault_i(gap_fault_i),
      .word_count_i(word_count_i),
      .sync_type_i(sync_type_i),
      .busy_i(busy_now),
      .illegal_i(illegal_bit_i),
      .bus_select_i(bus_select_i),
      .mode_code_i(mode_code_i),
      .info_word_o(info_now)
   );

   rms_word_reg rms_word_reg_i (
      .ref_clk_i(ref_clk_i),
      .resetn_i(resetn_i),
      .load_i(msg_done_i && st.state == rms_pkg::RMS_IDLE),
      .word_i(data_word_i),
      .word_o(held_data)
   );

   // ------------------------------------------------------------------
   // Write sequencer
   // ------------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.data_out_valid = 1'b0;
      case (st.state)
         rms_pkg::RMS_IDLE: begin
            if (msg_done_i) begin
               next_st.state = rms_pkg::RMS_INFO;
               next_st.base = data_ptr_i;
               next_st.info = info_now;
               next_st.tag = time_tag_i;
               next_st.with_data = has_data(mode_code_i) && data_valid_i;
               next_st.data_code = mode_code_i;
               if (has_data(mode_code_i) && data_good && !illegal_now && !busy_now) begin
                  next_st.data_out_valid = 1'b1;
                  next_st.data_out = data_word_i;
               end
            end
         end
         rms_pkg::RMS_INFO: begin
            if (ram_ready_i) begin
               next_st.state = rms_pkg::RMS_TAG;
            end
         end
         rms_pkg::RMS_TAG: begin
            if (ram_ready_i) begin
               next_st.state = st.with_data ? rms_pkg::RMS_DATA : rms_pkg::RMS_IDLE;
            end
         end
         rms_pkg::RMS_DATA: begin
            if (ram_ready_i) begin
               next_st.state = rms_pkg::RMS_IDLE;
            end
         end
         default: begin
            next_st.state = rms_pkg::RMS_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         st <= '{state: rms_pkg::RMS_IDLE, base: '0, info: rms_pkg::WORD_RESET,
                 tag: rms_pkg::WORD_RESET, with_data: 1'b0, data_out_valid: 1'b0,
                 data_code: 5'h00, data_out: rms_pkg::WORD_RESET};
      end else begin
         st <= next_st;
      end
   end

   // ------------------------------------------------------------------
   // RAM port
   // ------------------------------------------------------------------
   always_comb begin
      ram_we_o = 1'b0;
      ram_addr_o = st.base;
      ram_wdata_o = rms_pkg::WORD_RESET;
      case (st.state)
         rms_pkg::RMS_INFO: begin
            ram_we_o = 1'b1;
            ram_addr_o = offs(st.base, rms_pkg::INFO_OFFSET);
            ram_wdata_o = st.info;
         end
         rms_pkg::RMS_TAG: begin
            ram_we_o = 1'b1;
            ram_addr_o = offs(st.base, rms_pkg::TAG_OFFSET);
            ram_wdata_o = st.tag;
         end
         rms_pkg::RMS_DATA: begin
            ram_we_o = 1'b1;
            ram_addr_o = offs(st.base, rms_pkg::DATA_OFFSET);
            ram_wdata_o = held_data;
         end
         default: begin
            ram_we_o = 1'b0;
         end
      endcase
   end

   assign busy_o = (st.state != rms_pkg::RMS_IDLE);
   assign mode_data_valid_o = st.data_out_valid;
   assign mode_data_code_o = st.data_code;
   assign mode_data_o = st.data_out;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   property p_tag_after_info;
      @(posedge ref_clk_i) disable iff (!resetn_i)
         (st.state == rms_pkg::RMS_INFO && ram_ready_i) |=>
         (ram_we_o && ram_addr_o == offs(st.base, rms_pkg::TAG_OFFSET));
   endproperty
   a_tag_after_info: assert property (p_tag_after_info)
      else $error("tag write misplaced");

   property p_data_addr;
      @(posedge ref_clk_i) disable iff (!resetn_i)
         (st.state == rms_pkg::RMS_DATA) |->
         (ram_addr_o == offs(st.base, rms_pkg::DATA_OFFSET) && ram_wdata_o == held_data);
   endproperty
   a_data_addr: assert property (p_data_addr) else $error("data word address wrong");

   property p_info_first;
      @(posedge ref_clk_i) disable iff (!resetn_i)
         (!busy_o && msg_done_i) ##1 1'b1 |-> (ram_addr_o == $past(data_ptr_i) && ram_we_o);
   endproperty
   a_info_first: assert property (p_info_first)
      else $error("info word not at pointer");

   property p_no_data_short;
      @(posedge ref_clk_i) disable iff (!resetn_i)
         (!busy_o && msg_done_i && !has_data(mode_code_i)) |=>
         !(st.state == rms_pkg::RMS_DATA) [*3];
   endproperty
   a_no_data_short: assert property (p_no_data_short)
      else $error("data write on short record");

   property p_undef_refused;
      @(posedge ref_clk_i) disable iff (!resetn_i)
         (msg_done_i && undefined_mode_invalid_i && is_undefined(mode_code_i))
         |-> !respond_in_form_o;
   endproperty
   a_undef_refused: assert property (p_undef_refused)
      else $error("undefined code answered");

   property p_illegal_refused;
      @(posedge ref_clk_i) disable iff (!resetn_i)
         (msg_done_i && illegal_bit_i) |-> !respond_in_form_o && !responded_busy_o;
   endproperty
   a_illegal_refused: assert property (p_illegal_refused)
      else $error("illegal code answered");

   property p_summary;
      @(posedge ref_clk_i) disable iff (!resetn_i)
         (st.state == rms_pkg::RMS_INFO) |->
         (ram_wdata_o[rms_pkg::MSG_FAULT_BIT] == |ram_wdata_o[14:11]);
   endproperty
   a_summary: assert property (p_summary) else $error("fault summary mismatch");

   property p_zero_bits;
      @(posedge ref_clk_i) disable iff (!resetn_i)
         (st.state == rms_pkg::RMS_INFO) |->
         (ram_wdata_o[15] == 1'b0 && ram_wdata_o[7:6] == 2'b00);
   endproperty
   a_zero_bits: assert property (p_zero_bits) else $error("unused info bits set");

   property p_mode_code;
      @(posedge ref_clk_i) disable iff (!resetn_i)
         (!busy_o && msg_done_i) |=> (st.info[4:0] == $past(mode_code_i)
         && st.info[rms_pkg::BUS_SELECT_BIT] == $past(bus_select_i));
   endproperty
   a_mode_code: assert property (p_mode_code)
      else $error("mode code or bus id wrong");

   property p_tag_value;
      @(posedge ref_clk_i) disable iff (!resetn_i)
         (!busy_o && msg_done_i) |=> (st.tag == $past(time_tag_i));
   endproperty
   a_tag_value: assert property (p_tag_value) else $error("time tag not captured");

   property p_reset_idle;
      @(posedge ref_clk_i)
         !resetn_i |=> (!busy_o && !ram_we_o && !mode_data_valid_o);
   endproperty
   a_reset_idle: assert property (p_reset_idle)
      else $error("sequencer not idle after reset");

   property p_base_held;
      @(posedge ref_clk_i) disable iff (!resetn_i)
         busy_o |=> ($stable(st.base) && $stable(st.info) && $stable(st.tag));
   endproperty
   a_base_held: assert property (p_base_held)
      else $error("record changed while being written");

   property p_word_stands;
      @(posedge ref_clk_i) disable iff (!resetn_i)
         (ram_we_o && !ram_ready_i) |=>
         (ram_we_o && $stable(ram_addr_o) && $stable(ram_wdata_o));
   endproperty
   a_word_stands: assert property (p_word_stands)
      else $error("record word withdrawn before acceptance");

   property p_pulse_once;
      @(posedge ref_clk_i) disable iff (!resetn_i)
         mode_data_valid_o |=> !mode_data_valid_o;
   endproperty
   a_pulse_once: assert property (p_pulse_once)
      else $error("mode data offered twice");

   property p_dirty_word;
      @(posedge ref_clk_i) disable iff (!resetn_i)
         (!busy_o && msg_done_i && (invalid_word_i || gap_fault_i || sync_type_i))
         |=> !mode_data_valid_o;
   endproperty
   a_dirty_word: assert property (p_dirty_word)
      else $error("damaged mode data offered");

   property p_error_bits;
      @(posedge ref_clk_i) disable iff (!resetn_i)
         (!busy_o && msg_done_i) |=>
         (st.info[rms_pkg::INVALID_WORD_BIT] == $past(invalid_word_i)
         && st.info[rms_pkg::GAP_FAULT_BIT] == $past(gap_fault_i)
         && st.info[rms_pkg::WORD_COUNT_BIT] == $past(word_count_i)
         && st.info[rms_pkg::SYNC_TYPE_BIT] == $past(sync_type_i));
   endproperty
   a_error_bits: assert property (p_error_bits)
      else $error("error flag lost from info word");

   property p_busy_bit;
      @(posedge ref_clk_i) disable iff (!resetn_i)
         (!busy_o && msg_done_i && !illegal_bit_i && !undefined_mode_invalid_i
         && (global_busy_i || per_command_busy_i)) |=> st.info[rms_pkg::BUSY_BIT];
   endproperty
   a_busy_bit: assert property (p_busy_bit)
      else $error("busy answer not recorded");

   property p_plain_answered;
      @(posedge ref_clk_i) disable iff (!resetn_i)
         (msg_done_i && !illegal_bit_i && !undefined_mode_invalid_i && !global_busy_i
         && !per_command_busy_i) |-> respond_in_form_o;
   endproperty
   a_plain_answered: assert property (p_plain_answered)
      else $error("legal command not answered in form");
endmodule

// *** tb/rms_ram_model.sv ***
// Shared RAM model that accepts record writes promptly or slowly.
`timescale 1ns/1ps
module rms_ram_model (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   // Write port
   input wire logic ram_we_i,
   input wire logic [15:0] ram_addr_i,
   input wire logic [15:0] ram_wdata_i,
   output logic ram_ready_o,
   // Pace control
   input wire logic slow_i
);
   logic [15:0] mem [logic [15:0]];
   int writes;
   logic [1:0] pace;
   initial begin
      writes = 0;
      pace = 2'h0;
   end
   // Slow pace is ready on one cycle in four, so each word must stand on the port a while.
   assign ram_ready_o = !slow_i || (pace == 2'h3);
   always @(posedge ref_clk_i) begin
      pace <= pace + 2'h1;
      if (resetn_i && ram_we_i && ram_ready_o) begin
         mem[ram_addr_i] = ram_wdata_i;
         writes = writes + 1;
      end
   end
endmodule

// *** tb/test_rms_cmd_store.sv ***
// Self-checking testbench of the receive mode command store block.
`timescale 1ns/1ps
module test_rms_cmd_store;
   logic ref_clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic msg_done_i = 1'b0, data_valid_i = 1'b0, bus_select_i = 1'b0;
   logic [4:0] mode_code_i = 5'h00;
   logic [15:0] data_ptr_i = 16'h0000, data_word_i = 16'h0000, time_tag_i = 16'h0000;
   logic invalid_word_i = 1'b0, gap_fault_i = 1'b0, word_count_i = 1'b0, sync_type_i = 1'b0;
   logic illegal_bit_i = 1'b0, undefined_mode_invalid_i = 1'b0;
   logic global_busy_i = 1'b0, per_command_busy_i = 1'b0, slow = 1'b0;
   logic respond_in_form_o, responded_busy_o, mode_data_valid_o, ram_we_o, ram_ready_i, busy_o;
   logic [4:0] mode_data_code_o;
   logic [15:0] mode_data_o, ram_addr_o, ram_wdata_o;
   logic [15:0] next_ptr = 16'h1500;
   int err_count = 0, comparisons = 0, cycles = 0, i;
   localparam logic [4:0] UC [3] = '{rms_pkg::MC_UNDEF_A, rms_pkg::MC_UNDEF_B, rms_pkg::MC_UNDEF_C};
   always #2.5 ref_clk_i = ~ref_clk_i;
   rms_cmd_store rms_cmd_store_i (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
      .msg_done_i(msg_done_i), .mode_code_i(mode_code_i), .data_ptr_i(data_ptr_i),
      .data_valid_i(data_valid_i), .data_word_i(data_word_i), .time_tag_i(time_tag_i),
      .bus_select_i(bus_select_i), .invalid_word_i(invalid_word_i), .gap_fault_i(gap_fault_i),
      .word_count_i(word_count_i), .sync_type_i(sync_type_i), .illegal_bit_i(illegal_bit_i),
      .undefined_mode_invalid_i(undefined_mode_invalid_i), .global_busy_i(global_busy_i),
      .per_command_busy_i(per_command_busy_i), .respond_in_form_o(respond_in_form_o),
      .responded_busy_o(responded_busy_o), .mode_data_valid_o(mode_data_valid_o),
      .mode_data_code_o(mode_data_code_o), .mode_data_o(mode_data_o), .ram_we_o(ram_we_o),
      .ram_addr_o(ram_addr_o), .ram_wdata_o(ram_wdata_o), .ram_ready_i(ram_ready_i),
      .busy_o(busy_o));
   rms_ram_model rms_ram_model_i (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
      .ram_we_i(ram_we_o), .ram_addr_i(ram_addr_o), .ram_wdata_i(ram_wdata_o),
      .ram_ready_o(ram_ready_i), .slow_i(slow));
   // ------------------------------------------------------------------
   // Reporting
   // ------------------------------------------------------------------
   task automatic close_out;
      $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // A hang in the sequencer is cut short well after the longest record.
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         close_out();
      end
   end
   // ------------------------------------------------------------------
   // One receive mode message and the record it leaves in RAM
   // ------------------------------------------------------------------
   task automatic run_msg(input logic [4:0] code, input logic dv, input logic [3:0] errs,
         input logic bus, input logic ill, input logic umi, input logic [1:0] bsy,
         input logic slw, input logic poke);
      logic undef, illegal, busy, mdv;
      logic [15:0] ptr, info, dword;
      int base, n, k;
      ptr = next_ptr;
      next_ptr = next_ptr + 16'h0010;
      dword = ptr ^ 16'hc3c3;
      undef = (code < 5'h10) || code == UC[0] || code == UC[1] || code == UC[2];
      illegal = ill || (undef && umi);
      busy = (|bsy) && !illegal;
      // A word count fault alone does not spoil the data word itself.
      mdv = ((errs & 4'hd) == 4'h0) && !illegal && !busy && dv && (code >= 5'h10);
      info = {1'b0, errs, |errs, busy, ill, 2'b00, bus, code};
      n = (dv && code >= 5'h10) ? 3 : 2;
      base = rms_ram_model_i.writes;
      @(posedge ref_clk_i);
      #1;
      mode_code_i = code;
      data_ptr_i = ptr;
      data_valid_i = dv;
      data_word_i = dword;
      time_tag_i = ~ptr;
      bus_select_i = bus;
      {invalid_word_i, gap_fault_i, word_count_i, sync_type_i} = errs;
      illegal_bit_i = ill;
      undefined_mode_invalid_i = umi;
      {global_busy_i, per_command_busy_i} = bsy;
      slow = slw;
      msg_done_i = 1'b1;
      #1;
      check(respond_in_form_o, !illegal && !busy);
      check(responded_busy_o, busy);
      @(posedge ref_clk_i);
      #1;
      // A second completion while the record is being written must leave no trace.
      if (poke) data_ptr_i = ptr + 16'h0100;
      else msg_done_i = 1'b0;
      check(mode_data_valid_o, mdv);
      if (mdv) check(mode_data_code_o, code);
      if (mdv) check(mode_data_o, dword);
      @(posedge ref_clk_i);
      #1;
      msg_done_i = 1'b0;
      k = 0;
      while (busy_o !== 1'b0 && k < 40) begin
         @(posedge ref_clk_i);
         #1;
         k++;
      end
      check(k < 40, 1'b1);
      check(rms_ram_model_i.writes - base, n);
      check(rms_ram_model_i.mem[ptr], info);
      check(rms_ram_model_i.mem[ptr + 16'h0001], ~ptr);
      if (n == 3) check(rms_ram_model_i.mem[ptr + 16'h0002], dword);
      else check(rms_ram_model_i.mem.exists(ptr + 16'h0002), 1'b0);
   endtask
   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      repeat (4) @(posedge ref_clk_i);
      #1;
      resetn_i = 1'b1;
      check(busy_o, 1'b0);
      check(ram_we_o, 1'b0);
      check(mode_data_o, 16'h0000);
      run_msg(5'h11, 1, 4'h0, 0, 0, 0, 2'h0, 0, 0);
      run_msg(5'h05, 0, 4'h0, 1, 0, 0, 2'h0, 0, 0);
      for (i = 0; i < 6; i++) run_msg(UC[i % 3], 1, 4'h0, 0, 0, (i >= 3), 2'h0, 0, 0);
      run_msg(5'h02, 0, 4'h0, 0, 0, 1, 2'h0, 0, 0);
      run_msg(5'h0f, 0, 4'h0, 1, 0, 0, 2'h0, 0, 0);
      for (i = 0; i < 4; i++) run_msg(5'h14, 1, 4'h1 << i, 0, 0, 0, 2'h0, 0, 0);
      run_msg(5'h1f, 0, 4'h2, 1, 0, 0, 2'h0, 0, 0);
      run_msg(5'h15, 1, 4'h0, 1, 0, 0, 2'h2, 0, 0);
      run_msg(5'h18, 1, 4'h0, 0, 0, 0, 2'h1, 0, 0);
      run_msg(5'h16, 1, 4'h0, 0, 1, 0, 2'h2, 0, 0);
      run_msg(5'h03, 0, 4'h0, 1, 1, 0, 2'h0, 0, 0);
      run_msg(5'h17, 1, 4'h0, 1, 0, 0, 2'h0, 1, 1);
      run_msg(5'h09, 0, 4'h0, 0, 0, 0, 2'h0, 1, 1);
      run_msg(5'h11, 1, 4'h0, 0, 0, 1, 2'h0, 0, 0);
      run_msg(5'h04, 1, 4'h2, 0, 0, 0, 2'h0, 0, 0);
      // A reset in the middle of a slow record drops the write at once.
      @(posedge ref_clk_i);
      #1;
      mode_code_i = 5'h1a;
      data_valid_i = 1'b1;
      slow = 1'b1;
      msg_done_i = 1'b1;
      @(posedge ref_clk_i);
      #1;
      msg_done_i = 1'b0;
      resetn_i = 1'b0;
      @(posedge ref_clk_i);
      #1;
      check(busy_o, 1'b0);
      check(ram_we_o, 1'b0);
      check(mode_data_valid_o, 1'b0);
      check(mode_data_o, 16'h0000);
      resetn_i = 1'b1;
      run_msg(5'h10, 1, 4'h0, 1, 0, 0, 2'h0, 0, 0);
      close_out();
   end
endmodule
